/* File: common/baud_if.sv */
// operation clock and bit tick carrier between top and baud generator
`timescale 1ns/10ps
interface baud_if;
  logic       run;
  logic [3:0] prescale;
  logic [6:0] divider;
  logic       bit_tick;

  modport ctrl (output run, output prescale, output divider,
                input bit_tick);
  modport gen  (input run, input prescale, input divider,
                output bit_tick);
endinterface

/* File: common/uart_tx_pkg.sv */
// package with register map, field layout and timing constants
package uart_tx_pkg;

  // register byte offsets (aligned words)
  localparam logic [7:0] CHAN_DATA_DIVIDER_OFS = 8'h00;
  localparam logic [7:0] CHAN_COMM_CONFIG_OFS  = 8'h04;
  localparam logic [7:0] CHAN_STATUS_OFS       = 8'h08;
  localparam logic [7:0] CHAN_START_OFS        = 8'h0C;
  localparam logic [7:0] CHAN_STOP_OFS         = 8'h10;
  localparam logic [7:0] SERIAL_OUT_LEVEL_OFS  = 8'h14;
  localparam logic [7:0] SERIAL_OUT_ENABLE_OFS = 8'h18;
  localparam logic [7:0] CLOCK_GATE_OFS        = 8'h1C;

  // data/divider register fields
  localparam int DIV_LSB  = 9;
  localparam int DIV_W    = 7;
  localparam logic [6:0] DIV_MIN = 7'h02;

  // config register field positions
  localparam int CFG_LEN_LO   = 0;
  localparam int CFG_LEN_HI   = 1;
  localparam int CFG_PAR_LSB  = 2;
  localparam int CFG_STOP2    = 4;
  localparam int CFG_LSB_1ST  = 5;
  localparam int CFG_INVERT   = 6;
  localparam int CFG_IRQ_SRC  = 7;
  localparam int CFG_PRE_LSB  = 8;
  localparam logic [15:0] CFG_RESET = 16'h0023;

  // status register field positions
  localparam int STS_BUF_FULL = 0;
  localparam int STS_ACTIVE   = 6;
  localparam int STS_ENABLED  = 8;

  // channel and output bit positions for this transmit channel
  localparam int CHAN_BIT     = 0;
  localparam logic [15:0] OUT_LEVEL_RESET = 16'h0F0F;

  // operation clock prescaler width (fclk / 2^k, k = 0..15)
  localparam int PRE_W = 4;

  // divide-by-two applied after the divider value plus one
  localparam int HALF_BIT_STEPS = 2;

  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_ZERO = 2'b01,
    PAR_EVEN = 2'b10,
    PAR_ODD  = 2'b11
  } parity_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_SHIFT = 2'b10,
    ST_STOP  = 2'b11
  } tx_state_t;

endpackage

/* File: hdl/uart_tx_baud.sv */
// baud generator: prescaled operation clock then bit-period divider
`timescale 1ns/10ps
module uart_tx_baud
  import uart_tx_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  baud_if.gen       bif
);

  logic [15:0] pre_cnt_q;
  logic [7:0]  div_cnt_q;
  logic        half_q;
  logic        op_tick;

  // operation clock enable: one pulse every 2^prescale pclk cycles
  assign op_tick = ((pre_cnt_q & ((16'h0001 << bif.prescale) - 16'h0001))
                    == 16'h0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_q <= 16'h0000;
    end else if (!bif.run) begin
      pre_cnt_q <= 16'h0000;
    end else begin
      pre_cnt_q <= pre_cnt_q + 16'h0001;
    end
  end

  // bit period = (divider + 1) * 2 operation clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 8'h00;
      half_q    <= 1'b0;
      bif.bit_tick <= 1'b0;
    end else if (!bif.run) begin
      div_cnt_q <= 8'h00;
      half_q    <= 1'b0;
      bif.bit_tick <= 1'b0;
    end else begin
      bif.bit_tick <= 1'b0;
      if (op_tick) begin
        if (div_cnt_q >= {1'b0, bif.divider}) begin
          div_cnt_q <= 8'h00;
          half_q    <= ~half_q;
          bif.bit_tick <= half_q;
        end else begin
          div_cnt_q <= div_cnt_q + 8'h01;
        end
      end
    end
  end

endmodule

/* File: hdl/uart_tx_channel.sv */
// transmit channel of the serial unit with apb register slave
// Operation
// - frame is start bit, data, optional parity, stop bits, internal baud
// - this even channel only transmits; odd partner receives
// - data length 7, 8 or 9 bits; 9 only on first pair
// - software selects msb-first or lsb-first shifting
// - inversion selects idle-high normal or idle-low inverted output; idle shows the output level bit, which takes the stop level only after a frame
// - parity none, always zero, even or odd; receiver checks it
// - one or two stop bits appended; receiver checks stop bit
// - divider in data bits 15:9 at least 2; slowest fclk/(2*2^15*128)
// - receiver raises error interrupt on framing, parity, overrun errors
// - write while buffer full overwrites the pending word
// - interrupt mode bit may change during operation, before last bit
// - clock gate off resets unit; software reinitializes afterward
// - nine-bit mode takes word from data register bits 0 to 8
// - a pair used for this function serves only this function
// - one function per channel; other channels stay free
`timescale 1ns/10ps
module uart_tx_channel
  import uart_tx_pkg::*;
#(
  parameter bit NINE_BIT_OK = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             txd,
  output logic             transmit_irq
);

  baud_if bif ();

  logic [15:0] channel_data_divider_q;
  logic [15:0] channel_comm_config_q;
  logic [15:0] serial_output_level_q;
  logic        serial_output_enable_q;
  logic        peripheral_clock_gate_q;
  logic        channel_enabled_q;
  logic        buffer_full_q;
  logic [8:0]  shift_q;
  logic [3:0]  bit_cnt_q;
  logic        parity_acc_q;
  logic        stop_cnt_q;
  tx_state_t   state_q;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        unit_rst;
  logic [3:0]  data_len;
  logic        cur_bit;
  parity_t     par_mode;
  logic        active;
  logic        load_word;
  logic        line_bit;

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      CHAN_DATA_DIVIDER_OFS, CHAN_COMM_CONFIG_OFS, CHAN_STATUS_OFS,
      CHAN_START_OFS, CHAN_STOP_OFS, SERIAL_OUT_LEVEL_OFS,
      SERIAL_OUT_ENABLE_OFS, CLOCK_GATE_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // zero-wait slave; unmapped addresses answer with pslverr
  assign addr_ok = mapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en   = psel & penable & pwrite & addr_ok;
  // reads latch in the setup cycle, so data stands at the access edge
  assign rd_en   = psel & ~penable & ~pwrite;
  // clock gate low holds the whole unit in reset
  assign unit_rst = ~peripheral_clock_gate_q;

  // length code 11 = 9 bits, 10 = 8 bits, 01/00 = 7 bits
  always_comb begin
    if (channel_comm_config_q[CFG_LEN_HI] && channel_comm_config_q[CFG_LEN_LO]
        && NINE_BIT_OK) begin
      data_len = 4'h9;
    end else if (channel_comm_config_q[CFG_LEN_HI]) begin
      data_len = 4'h8;
    end else begin
      data_len = 4'h7;
    end
  end

  assign par_mode = parity_t'(channel_comm_config_q[CFG_PAR_LSB +: 2]);
  assign active   = (state_q != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // peripheral clock gate, kept outside the unit reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_clock_gate_q <= 1'b0;
    end else if (wr_en && paddr == CLOCK_GATE_OFS) begin
      peripheral_clock_gate_q <= pwdata[0];
    end
  end

  // configuration and output setup registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_comm_config_q  <= CFG_RESET;
      serial_output_level_q  <= OUT_LEVEL_RESET;
      serial_output_enable_q <= 1'b0;
    end else if (unit_rst) begin
      channel_comm_config_q  <= CFG_RESET;
      serial_output_level_q  <= OUT_LEVEL_RESET;
      serial_output_enable_q <= 1'b0;
    end else begin
      // mode bit accepted even while transmitting
      if (wr_en && paddr == CHAN_COMM_CONFIG_OFS) begin
        channel_comm_config_q <= pwdata[15:0];
      end
      if (wr_en && paddr == SERIAL_OUT_ENABLE_OFS) begin
        serial_output_enable_q <= pwdata[CHAN_BIT];
      end
      // direct level writes only hold while channel stopped
      if (wr_en && paddr == SERIAL_OUT_LEVEL_OFS && !channel_enabled_q) begin
        serial_output_level_q <= pwdata[15:0];
      end else if (channel_enabled_q && active) begin
        // level bit tracks the line, so idle resumes at the stop level
        serial_output_level_q[CHAN_BIT] <= line_bit;
      end
    end
  end

  // start/stop triggers set and clear the enabled status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_enabled_q <= 1'b0;
    end else if (unit_rst) begin
      channel_enabled_q <= 1'b0;
    end else if (wr_en && paddr == CHAN_STOP_OFS && pwdata[CHAN_BIT]) begin
      channel_enabled_q <= 1'b0;
    end else if (wr_en && paddr == CHAN_START_OFS && pwdata[CHAN_BIT]) begin
      channel_enabled_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data register and buffer-full flag
  assign load_word = channel_enabled_q && buffer_full_q &&
                     (state_q == ST_IDLE ||
                      (state_q == ST_STOP && bif.bit_tick &&
                       (stop_cnt_q || !channel_comm_config_q[CFG_STOP2])));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_data_divider_q <= 16'h0000;
      buffer_full_q          <= 1'b0;
    end else if (unit_rst) begin
      channel_data_divider_q <= 16'h0000;
      buffer_full_q          <= 1'b0;
    end else if (wr_en && paddr == CHAN_DATA_DIVIDER_OFS) begin
      // divider field only changes while stopped; data always
      if (!channel_enabled_q) begin
        channel_data_divider_q <= pwdata[15:0];
      end else begin
        channel_data_divider_q[8:0] <= pwdata[8:0];
      end
      buffer_full_q <= channel_enabled_q; // set wins over the load
    end else if (load_word) begin
      buffer_full_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // baud generator hookup; divider below minimum is clamped
  assign bif.run      = channel_enabled_q & active;
  assign bif.prescale = channel_comm_config_q[CFG_PRE_LSB +: PRE_W];
  assign bif.divider  =
    (channel_data_divider_q[DIV_LSB +: DIV_W] < DIV_MIN) ?
    DIV_MIN : channel_data_divider_q[DIV_LSB +: DIV_W];

  uart_tx_baud u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .bif     (bif.gen)
  );

  // next data bit by direction
  assign cur_bit = channel_comm_config_q[CFG_LSB_1ST] ? shift_q[0]
                   : shift_q[data_len - 4'h1];

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= ST_IDLE;
      shift_q      <= 9'h000;
      bit_cnt_q    <= 4'h0;
      parity_acc_q <= 1'b0;
      stop_cnt_q   <= 1'b0;
    end else if (unit_rst || !channel_enabled_q) begin
      state_q <= ST_IDLE; // urgent stop aborts the frame
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (load_word) begin
            shift_q      <= channel_data_divider_q[8:0];
            parity_acc_q <= 1'b0;
            state_q      <= ST_START;
          end
        end
        ST_START: begin
          if (bif.bit_tick) begin
            bit_cnt_q <= 4'h0;
            state_q   <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (bif.bit_tick) begin
            parity_acc_q <= parity_acc_q ^ cur_bit;
            if (channel_comm_config_q[CFG_LSB_1ST]) begin
              shift_q <= {1'b0, shift_q[8:1]};
            end else begin
              shift_q <= {shift_q[7:0], 1'b0};
            end
            if (bit_cnt_q == data_len - 4'h1 + (par_mode != PAR_NONE)) begin
              stop_cnt_q <= 1'b0;
              state_q    <= ST_STOP;
            end
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
        end
        ST_STOP: begin
          if (bif.bit_tick) begin
            if (channel_comm_config_q[CFG_STOP2] && !stop_cnt_q) begin
              stop_cnt_q <= 1'b1;
            end else if (load_word) begin
              shift_q      <= channel_data_divider_q[8:0];
              parity_acc_q <= 1'b0;
              state_q      <= ST_START;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line level: frame bit before inversion
  logic raw_bit;
  logic par_bit;
  always_comb begin
    case (par_mode)
      PAR_ZERO: par_bit = 1'b0;
      PAR_EVEN: par_bit = parity_acc_q;
      PAR_ODD:  par_bit = ~parity_acc_q;
      default:  par_bit = 1'b0;
    endcase
    case (state_q)
      ST_START: raw_bit = 1'b0;
      ST_SHIFT: raw_bit = (bit_cnt_q >= data_len) ? par_bit : cur_bit;
      default:  raw_bit = 1'b1;
    endcase
  end

  // line level after inversion
  assign line_bit = raw_bit ^ channel_comm_config_q[CFG_INVERT];

  // registered output; idle shows the output level bit, left at the stop level after a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd <= 1'b1;
    end else if (!serial_output_enable_q || !active) begin
      txd <= serial_output_level_q[CHAN_BIT];
    end else begin
      txd <= line_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit interrupt: buffer empty or transfer end pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_irq <= 1'b0;
    end else if (channel_comm_config_q[CFG_IRQ_SRC]) begin
      transmit_irq <= load_word;
    end else begin
      transmit_irq <= (state_q == ST_STOP) && bif.bit_tick && !load_word &&
                      (stop_cnt_q || !channel_comm_config_q[CFG_STOP2]);
    end
  end

  // read mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        CHAN_DATA_DIVIDER_OFS: prdata <= {16'h0000, channel_data_divider_q};
        CHAN_COMM_CONFIG_OFS:  prdata <= {16'h0000, channel_comm_config_q};
        CHAN_STATUS_OFS: begin
          prdata <= 32'h0000_0000;
          prdata[STS_BUF_FULL] <= buffer_full_q;
          prdata[STS_ACTIVE]   <= active;
          prdata[STS_ENABLED]  <= channel_enabled_q;
        end
        SERIAL_OUT_LEVEL_OFS:  prdata <= {16'h0000, serial_output_level_q};
        SERIAL_OUT_ENABLE_OFS: prdata <= {31'h0, serial_output_enable_q};
        CLOCK_GATE_OFS:        prdata <= {31'h0, peripheral_clock_gate_q};
        default:               prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

/* File: verif/uart_line_receiver.sv */
// far side line receiver model sampling each bit mid-period
`timescale 1ns/10ps
module uart_line_receiver (
  input  wire logic        pclk,
  input  wire logic        txd,
  input  wire logic        inv,
  input  wire logic        arm,
  input  wire logic [31:0] nbits,
  input  wire logic [31:0] bit_cyc,
  output logic      [12:0] rx_bits,
  output int               rx_cnt
);
  ////////////////////////////////////////////////////////////////////////
  // hunt for a start edge; bits stored after undoing inversion
  initial begin
    rx_bits = '0;
    rx_cnt = 0;
    forever begin
      @(posedge pclk);
      if (arm && (txd ^ inv) === 1'b0) begin
        rx_bits = '0;
        repeat (bit_cyc / 2) @(posedge pclk);
        for (int i = 0; i < nbits; i++) begin
          if (i > 0) repeat (bit_cyc) @(posedge pclk);
          rx_bits[i] = txd ^ inv;
        end
        rx_cnt++;
      end
    end
  end
endmodule

/* File: verif/uart_transmit_channel_bench.sv */
// self-checking bench for the transmit channel
`timescale 1ns/10ps
module uart_transmit_channel_bench
  import uart_tx_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        txd;
  logic        transmit_irq;
  logic        inv;
  logic        arm;
  logic [12:0] rx_bits;
  logic [12:0] fexp;
  logic [31:0] rd;
  logic        err;
  int          rx_cnt;
  int          nbits;
  int          bit_cyc;
  int          irq_cnt;
  int          cycles;
  int          base;
  int          ib;
  int          num_errors;
  int          check_count;
  logic [15:0] cfgs [5] = '{16'h0022, 16'h0018, 16'h006F, 16'h0116, 16'h006A};
  logic [8:0]  words [5] = '{9'h0A5, 9'h053, 9'h1C3, 9'h0FF, 9'h081};
  ////////////////////////////////////////////////////////////////////////
  uart_tx_channel u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .txd(txd),
    .transmit_irq(transmit_irq)
  );
  uart_line_receiver u_rx (
    .pclk(pclk),
    .txd(txd),
    .inv(inv),
    .arm(arm),
    .nbits(nbits),
    .bit_cyc(bit_cyc),
    .rx_bits(rx_bits),
    .rx_cnt(rx_cnt)
  );
  ////////////////////////////////////////////////////////////////////////
  always #20 pclk = ~pclk;
  // irq pulses counted; hang cut short by a cycle ceiling
  always @(posedge pclk) begin
    cycles++;
    if (transmit_irq === 1'b1) irq_cnt++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // answer taken at the access edge; one idle clock keeps strobes apart
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_frame(input logic [12:0] got, input logic [12:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t frame %b expected %b", $time, got, exp);
    end
  endtask
  // expected line bits from start to last stop, idle level as 1
  function automatic int frame(input logic [8:0] d, input logic [15:0] c,
                               output logic [12:0] f);
    int n;
    int k;
    logic p;
    n = c[1:0] == 2'b11 ? 9 : (c[1:0] == 2'b10 ? 8 : 7);
    f = '0;
    k = 1;
    p = 1'b0;
    for (int i = 0; i < n; i++) begin
      f[k] = c[CFG_LSB_1ST] ? d[i] : d[n - 1 - i];
      p ^= d[i];
      k++;
    end
    if (c[3:2] != PAR_NONE) begin
      f[k] = c[3:2] == PAR_ODD ? ~p : (c[3:2] == PAR_EVEN ? p : 1'b0);
      k++;
    end
    f[k] = 1'b1;
    f[k + 1] = c[CFG_STOP2];
    return k + 1 + int'(c[CFG_STOP2]);
  endfunction
  // channel is stopped here, so divider and level writes take hold
  task automatic setup(input logic [15:0] c);
    arm <= 1'b0;
    apb(CHAN_COMM_CONFIG_OFS, 1'b1, {16'h0000, c});
    apb(SERIAL_OUT_LEVEL_OFS, 1'b1, {31'h0, ~c[CFG_INVERT]});
    apb(CHAN_DATA_DIVIDER_OFS, 1'b1, {16'h0000, DIV_MIN, 9'h000});
    apb(SERIAL_OUT_ENABLE_OFS, 1'b1, 32'h00000001);
    apb(CHAN_START_OFS, 1'b1, 32'h00000001);
    inv <= c[CFG_INVERT];
    nbits <= frame(9'h000, c, fexp);
    bit_cyc <= (int'(DIV_MIN) + 1) * HALF_BIT_STEPS << c[11:8];
    arm <= 1'b1;
    base = rx_cnt;
    ib = irq_cnt;
  endtask
  task automatic wait_frame(input logic [8:0] d, input logic [15:0] c);
    while (rx_cnt == base) @(posedge pclk);
    base++;
    void'(frame(d, c, fexp));
    check_frame(rx_bits, fexp);
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {pclk, presetn, psel, penable, pwrite, inv, arm} = '0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    {nbits, bit_cyc, irq_cnt, cycles, num_errors, check_count} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(CLOCK_GATE_OFS, 1'b1, 32'h00000001);
    check_val({31'h0, txd}, 32'h00000001);
    apb(CHAN_COMM_CONFIG_OFS, 1'b0, 32'h00000000);
    check_val(rd, {16'h0000, CFG_RESET});
    apb(SERIAL_OUT_LEVEL_OFS, 1'b0, 32'h00000000);
    check_val(rd, {16'h0000, OUT_LEVEL_RESET});
    apb(8'h20, 1'b0, 32'h00000000);
    check_val({err, rd[30:0]}, 32'h80000000);
    // lengths, parities, stop counts, bit orders, inversion, prescale
    for (int i = 0; i < 5; i++) begin
      setup(cfgs[i]);
      apb(CHAN_DATA_DIVIDER_OFS, 1'b1, {16'h0000, DIV_MIN, words[i]});
      wait_frame(words[i], cfgs[i]);
      repeat (3 * bit_cyc) @(posedge pclk);
      check_val(32'(irq_cnt - ib), 32'h00000001);
      apb(CHAN_STATUS_OFS, 1'b0, 32'h00000000);
      check_val(rd & 32'h00000141, 32'h00000100);
      apb(CHAN_STOP_OFS, 1'b1, 32'h00000001);
      apb(CHAN_STATUS_OFS, 1'b0, 32'h00000000);
      check_val(rd & 32'h00000141, 32'h00000000);
    end
    // continuous mode: third word overwrites the waiting second one
    setup(16'h00A2);
    apb(CHAN_DATA_DIVIDER_OFS, 1'b1, {16'h0000, DIV_MIN, 9'h03C});
    apb(CHAN_DATA_DIVIDER_OFS, 1'b1, {16'h0000, DIV_MIN, 9'h0F0});
    apb(CHAN_DATA_DIVIDER_OFS, 1'b1, {16'h0000, DIV_MIN, 9'h099});
    apb(CHAN_STATUS_OFS, 1'b0, 32'h00000000);
    check_val(rd & 32'h00000041, 32'h00000041);
    wait_frame(9'h03C, 16'h00A2);
    wait_frame(9'h099, 16'h00A2);
    repeat (200) @(posedge pclk);
    check_val(32'(rx_cnt - base), 32'h00000000);
    check_val(32'(irq_cnt - ib), 32'h00000002);
    apb(CHAN_STOP_OFS, 1'b1, 32'h00000001);
    apb(SERIAL_OUT_ENABLE_OFS, 1'b1, 32'h00000000);
    apb(SERIAL_OUT_ENABLE_OFS, 1'b0, 32'h00000000);
    check_val(rd, 32'h00000000);
    apb(CLOCK_GATE_OFS, 1'b1, 32'h00000000);
    apb(CHAN_COMM_CONFIG_OFS, 1'b0, 32'h00000000);
    check_val(rd, {16'h0000, CFG_RESET});
    give_verdict();
  end
endmodule

/* File: verif/uart_tx_channel_props.sv */
// port assertions for the transmit channel
`timescale 1ns/10ps
module uart_tx_channel_props
  import uart_tx_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        txd,
  input wire logic        transmit_irq
);
  ////////////////////////////////////////////////////////////////////////
  logic wr;
  logic ctl_wr;
  logic ctl_q;
  logic inv_q;
  logic src_q;
  logic en_q;
  logic gate_q;
  logic lvl_q;
  logic hit;
  // any write but data may legally move the line at once
  assign wr = psel && penable && pwrite;
  assign ctl_wr = wr && (paddr != CHAN_DATA_DIVIDER_OFS);
  assign hit = paddr <= CLOCK_GATE_OFS && paddr[1:0] == 2'h0;
  wire s_lvl = wr && paddr == SERIAL_OUT_LEVEL_OFS && gate_q && !en_q;
  // shadows of the settings software has written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 1'b0;
      inv_q <= 1'b0;
      src_q <= 1'b0;
      en_q <= 1'b0;
      gate_q <= 1'b0;
      lvl_q <= 1'b1;
    end else begin
      ctl_q <= ctl_wr;
      if (wr && paddr == CHAN_COMM_CONFIG_OFS) begin
        inv_q <= pwdata[CFG_INVERT];
        src_q <= pwdata[CFG_IRQ_SRC];
      end
      if (wr && paddr == CLOCK_GATE_OFS) begin
        gate_q <= pwdata[0];
      end
      if (wr && paddr == CHAN_START_OFS && pwdata[CHAN_BIT]) begin
        en_q <= gate_q;
      end
      if (wr && paddr == CHAN_STOP_OFS && pwdata[CHAN_BIT]) begin
        en_q <= 1'b0;
      end
      if (s_lvl) begin
        lvl_q <= pwdata[CHAN_BIT];
      end
    end
  end
  sequence s_lvl_wr;
    s_lvl;
  endsequence
  sequence s_hold;
    ($stable(txd) || ctl_wr || ctl_q) [*5];
  endsequence
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_idle_after_reset: assert property ($rose(presetn) |-> txd)
    else $error("line not idle after reset");
  a_bit_min_width: assert property ($changed(txd) |=> s_hold)
    else $error("bit shorter than six clocks");
  a_irq_single_pulse: assert property (transmit_irq |=> !transmit_irq)
    else $error("irq longer than one clock");
  a_end_irq_idle: assert property (
    transmit_irq && !src_q |-> txd == !inv_q)
    else $error("transfer end irq while line not idle");
  a_irq_needs_en: assert property (transmit_irq |-> en_q || $past(en_q))
    else $error("irq from a stopped channel");
  a_level_direct: assert property (s_lvl_wr |=> ##[0:1] txd == lvl_q)
    else $error("output level not applied");
  a_apb_err: assert property (psel && penable |-> pslverr == !hit)
    else $error("slave error wrong");
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("wait state inserted");
endmodule
bind uart_tx_channel uart_tx_channel_props u_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pready(pready),
  .pslverr(pslverr),
  .txd(txd),
  .transmit_irq(transmit_irq)
);
